//--- bnr_host.sv
// host sequencer for a byte-wide asynchronous nonvolatile memory port
//
// Notes on behaviour
// [RL1] the memory latches the address when chip select falls and starts a write at once if the write strobe is already low.
// [RL2] the output strobe only gates the memory's data drivers and never starts or ends a cycle.
// [RL3] whichever of chip select and write strobe falls last and rises first times a write, with no spacing needed between them.
// [RL4] the host waits at least 10 ms after power is good before its first access.
// [RL5] chip select stays low at least 70 ns in every cycle.
// [RL6] read data is valid on the bus at most 70 ns after chip select falls.
// [RL7] read data is driven at most 12 ns after the output strobe falls with chip select low and write strobe high.
// [RL8] the memory floats the bus at most 15 ns after output strobe or chip select rises.
// [RL9] the memory floats its outputs within 15 ns of the write strobe falling and drives again no sooner than 10 ns after it rises.
// [RL10] a strobe-timed write keeps the write strobe low at least 40 ns.
// [RL11] at least 70 ns pass from chip select falling to the write strobe rising.
// [RL12] power may go as soon as the last write strobe has risen.
// [RL13] chip select stays high at least 60 ns between cycles and each cycle lasts at least 130 ns.
// [RL14] with chip select high the memory ignores the write strobe and keeps its outputs floating.
`timescale 1ns/1ns
`include "bnr_defines.svh"
module bnr_host
  import bnr_pkg::*;
#(
  parameter int unsigned PWRUP_CYC = `BNR_PU_CYC
)
(
  input  wire logic      core_clk,
  input  wire logic      rst_b,
  input  wire logic      reqValid,
  output logic           reqReady,
  input  wire logic      reqWrite,
  input  wire bnr_addr_t reqAddr,
  input  wire bnr_data_t reqWdata,
  output logic           rspValid,
  output bnr_data_t      rspRdata,
  output logic           powerReady,
  output logic           memChipSelN,
  output logic           memWriteStrobeN,
  output logic           memOutStrobeN,
  output bnr_addr_t      memAddr,
  output bnr_data_t      memDataOut,
  output logic           memDataOe,
  input  wire bnr_data_t memDataIn
);

  localparam logic [`BNR_CNT_W-1:0] RD_LOW_END =
    `BNR_CNT_W'(`BNR_RD_LOW_CYC - 1);
  localparam logic [`BNR_CNT_W-1:0] WR_LOW_END =
    `BNR_CNT_W'(`BNR_WR_LOW_CYC - 1);
  localparam logic [`BNR_CNT_W-1:0] RD_PRE_END =
    `BNR_CNT_W'(`BNR_RD_PRE_CYC - 1);
  localparam logic [`BNR_CNT_W-1:0] WR_PRE_END =
    `BNR_CNT_W'(`BNR_WR_PRE_CYC - 1);
  localparam logic [31:0] PU_END = 32'(PWRUP_CYC - 1);

  bnr_pin_if ctl ();

  bnr_state_e             state_r, state_nxt;
  logic [31:0]            puCnt_r, puCnt_nxt;
  logic [`BNR_CNT_W-1:0]  cnt_r, cnt_nxt;
  logic                   isWrite_r, isWrite_nxt;
  logic                   ceN_r, ceN_nxt;
  logic                   weN_r, weN_nxt;
  logic                   oeN_r, oeN_nxt;
  logic                   drive_r, drive_nxt;
  bnr_addr_t              addr_r, addr_nxt;
  bnr_data_t              wdata_r, wdata_nxt;
  logic                   rspValid_r, rspValid_nxt;
  bnr_data_t              rdata_r, rdata_nxt;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt    = state_r;
    puCnt_nxt    = puCnt_r;
    cnt_nxt      = cnt_r;
    isWrite_nxt  = isWrite_r;
    ceN_nxt      = ceN_r;
    weN_nxt      = weN_r;
    oeN_nxt      = oeN_r;
    drive_nxt    = drive_r;
    addr_nxt     = addr_r;
    wdata_nxt    = wdata_r;
    rspValid_nxt = 1'b0;
    rdata_nxt    = rdata_r;
    case (state_r)
      BNR_PWRUP: begin
        // no access until the power-up wait has run out
        if (puCnt_r >= PU_END) begin // RL4
          state_nxt = BNR_IDLE;
        end else begin
          puCnt_nxt = puCnt_r + 32'h1;
        end
      end
      BNR_IDLE: begin
        if (reqValid) begin
          // address is set up with the chip select fall
          state_nxt   = BNR_ACTIVE; // RL1
          cnt_nxt     = 8'h00;
          isWrite_nxt = reqWrite;
          addr_nxt    = reqAddr;
          wdata_nxt   = reqWdata;
          ceN_nxt     = 1'b0;
          weN_nxt     = 1'b1;
          // reads open the drivers; writes keep them shut
          oeN_nxt     = reqWrite; // RL2
          drive_nxt   = reqWrite;
        end
      end
      BNR_ACTIVE: begin
        cnt_nxt = cnt_r + 8'h01;
        if (isWrite_r) begin
          // strobe falls after select, so the strobe times the write
          if (cnt_r == 8'h00) begin
            weN_nxt = 1'b0; // RL3
          end
          // select and strobe rise together after both minimums
          if (cnt_r == WR_LOW_END) begin // RL5 RL10 RL11
            state_nxt = BNR_PRECHG;
            cnt_nxt   = 8'h00;
            ceN_nxt   = 1'b1;
            weN_nxt   = 1'b1; // RL12
            drive_nxt = 1'b0;
          end
        end else if (cnt_r == RD_LOW_END) begin // RL5 RL6 RL7
          // synchronised data was sampled while select was low
          state_nxt    = BNR_PRECHG;
          cnt_nxt      = 8'h00;
          ceN_nxt      = 1'b1;
          oeN_nxt      = 1'b1; // RL8
          rspValid_nxt = 1'b1;
          rdata_nxt    = ctl.rdataSync;
        end
      end
      BNR_PRECHG: begin
        cnt_nxt = cnt_r + 8'h01;
        // memory floats while select is high, so the next write may drive
        if ((isWrite_r && cnt_r == WR_PRE_END) ||
            (!isWrite_r && cnt_r == RD_PRE_END)) begin // RL13 RL14 RL9
          state_nxt = BNR_IDLE;
          cnt_nxt   = 8'h00;
        end
      end
      default: begin
        state_nxt = BNR_PWRUP;
        ceN_nxt   = 1'b1;
        weN_nxt   = 1'b1;
        oeN_nxt   = 1'b1;
        drive_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r    <= BNR_PWRUP;
      puCnt_r    <= 32'h0;
      cnt_r      <= 8'h00;
      isWrite_r  <= 1'b0;
      ceN_r      <= `BNR_STROBE_IDLE;
      weN_r      <= `BNR_STROBE_IDLE;
      oeN_r      <= `BNR_STROBE_IDLE;
      drive_r    <= 1'b0;
      addr_r     <= 13'h0000;
      wdata_r    <= 8'h00;
      rspValid_r <= 1'b0;
      rdata_r    <= 8'h00;
    end else begin
      state_r    <= state_nxt;
      puCnt_r    <= puCnt_nxt;
      cnt_r      <= cnt_nxt;
      isWrite_r  <= isWrite_nxt;
      ceN_r      <= ceN_nxt;
      weN_r      <= weN_nxt;
      oeN_r      <= oeN_nxt;
      drive_r    <= drive_nxt;
      addr_r     <= addr_nxt;
      wdata_r    <= wdata_nxt;
      rspValid_r <= rspValid_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reqReady   = (state_r == BNR_IDLE);
  assign powerReady = (state_r != BNR_PWRUP);
  assign rspValid   = rspValid_r;
  assign rspRdata   = rdata_r;

  assign ctl.chipSelN     = ceN_r;
  assign ctl.writeStrobeN = weN_r;
  assign ctl.outStrobeN   = oeN_r;
  assign ctl.addr         = addr_r;
  assign ctl.wdata        = wdata_r;
  assign ctl.driveData    = drive_r;

  bnr_pin_io u_pins (
    .core_clk        (core_clk),
    .rst_b           (rst_b),
    .ctl             (ctl.pins),
    .memChipSelN     (memChipSelN),
    .memWriteStrobeN (memWriteStrobeN),
    .memOutStrobeN   (memOutStrobeN),
    .memAddr         (memAddr),
    .memDataOut      (memDataOut),
    .memDataOe       (memDataOe),
    .memDataIn       (memDataIn)
  );

endmodule

//--- bnr_defines.svh
// timing, width and reset constants of the byte-wide memory host port
`ifndef BNR_DEFINES_SVH
`define BNR_DEFINES_SVH

`define BNR_ADDR_W        13
`define BNR_DATA_W        8
`define BNR_SYNC_STAGES   2

// clock period and device times, each in its own unit
`define BNR_CLK_PERIOD_NS 40
`define BNR_T_PU_MS       10
`define BNR_T_CA_NS       70
`define BNR_T_ACC_NS      70
`define BNR_T_CW_NS       70
`define BNR_T_WP_NS       40
`define BNR_T_PC_NS       60
`define BNR_T_RC_NS       130

// least times round up to whole clock cycles
`define BNR_CEIL_CYC(ns) (((ns) + `BNR_CLK_PERIOD_NS - 1) / `BNR_CLK_PERIOD_NS)
`define BNR_MAX(a, b) (((a) > (b)) ? (a) : (b))

`define BNR_PU_CYC \
  ((`BNR_T_PU_MS * 1000000 + `BNR_CLK_PERIOD_NS - 1) / `BNR_CLK_PERIOD_NS)
`define BNR_ACC_CYC   `BNR_CEIL_CYC(`BNR_T_ACC_NS)
`define BNR_CA_CYC    `BNR_CEIL_CYC(`BNR_T_CA_NS)
`define BNR_CW_CYC    `BNR_CEIL_CYC(`BNR_T_CW_NS)
`define BNR_WP_CYC    `BNR_CEIL_CYC(`BNR_T_WP_NS)
`define BNR_PC_CYC    `BNR_CEIL_CYC(`BNR_T_PC_NS)
`define BNR_RC_CYC    `BNR_CEIL_CYC(`BNR_T_RC_NS)
// read: output register stage, access time, sync stages, one settle cycle
`define BNR_RD_LOW_CYC (`BNR_MAX(`BNR_ACC_CYC, `BNR_CA_CYC) \
  + `BNR_SYNC_STAGES + 2)
// write: one cycle with strobe high, then strobe low
`define BNR_WR_LOW_CYC `BNR_MAX(`BNR_MAX(`BNR_CW_CYC, `BNR_CA_CYC), \
  `BNR_WP_CYC + 1)
`define BNR_RD_PRE_CYC `BNR_MAX(`BNR_PC_CYC, `BNR_RC_CYC - `BNR_RD_LOW_CYC)
`define BNR_WR_PRE_CYC `BNR_MAX(`BNR_PC_CYC, `BNR_RC_CYC - `BNR_WR_LOW_CYC)

// pin levels after reset and sequencer counter width
`define BNR_STROBE_IDLE   1'b1
`define BNR_CNT_W         8

`endif

//--- bnr_pkg.sv
// types shared by the byte-wide memory host port
package bnr_pkg;

  typedef enum logic [1:0] {
    BNR_PWRUP  = 2'b00,
    BNR_IDLE   = 2'b01,
    BNR_ACTIVE = 2'b11,
    BNR_PRECHG = 2'b10
  } bnr_state_e;

  typedef logic [12:0] bnr_addr_t;
  typedef logic [7:0]  bnr_data_t;

endpackage

//--- bnr_pin_if.sv
// control bundle between the sequencer and the pin stage
`timescale 1ns/1ns
interface bnr_pin_if;
  import bnr_pkg::*;

  logic      chipSelN;
  logic      writeStrobeN;
  logic      outStrobeN;
  bnr_addr_t addr;
  bnr_data_t wdata;
  logic      driveData;
  bnr_data_t rdataSync;

  modport core (
    output chipSelN,
    output writeStrobeN,
    output outStrobeN,
    output addr,
    output wdata,
    output driveData,
    input  rdataSync
  );

  modport pins (
    input  chipSelN,
    input  writeStrobeN,
    input  outStrobeN,
    input  addr,
    input  wdata,
    input  driveData,
    output rdataSync
  );
endinterface

//--- bnr_pin_io.sv
// pin stage: output registers toward the memory and data input synchroniser
`timescale 1ns/1ns
`include "bnr_defines.svh"
module bnr_pin_io
  import bnr_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      rst_b,
  bnr_pin_if.pins        ctl,
  output logic           memChipSelN,
  output logic           memWriteStrobeN,
  output logic           memOutStrobeN,
  output bnr_addr_t      memAddr,
  output bnr_data_t      memDataOut,
  output logic           memDataOe,
  input  wire bnr_data_t memDataIn
);

  bnr_data_t syncStage_r [`BNR_SYNC_STAGES];
  bnr_data_t syncStage_nxt [`BNR_SYNC_STAGES];

  // ---------------------------------------------------------------
  // data input synchroniser
  // ---------------------------------------------------------------
  always_comb begin
    syncStage_nxt[0] = memDataIn;
  end

  genvar gi;
  generate
    for (gi = 1; gi < `BNR_SYNC_STAGES; gi++) begin : g_sync
      always_comb begin
        syncStage_nxt[gi] = syncStage_r[gi-1];
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `BNR_SYNC_STAGES; i++) begin
        syncStage_r[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < `BNR_SYNC_STAGES; i++) begin
        syncStage_r[i] <= syncStage_nxt[i];
      end
    end
  end

  assign ctl.rdataSync = syncStage_r[`BNR_SYNC_STAGES-1];

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      memChipSelN     <= `BNR_STROBE_IDLE;
      memWriteStrobeN <= `BNR_STROBE_IDLE;
      memOutStrobeN   <= `BNR_STROBE_IDLE;
      memAddr         <= 13'h0000;
      memDataOut      <= 8'h00;
      memDataOe       <= 1'b0;
    end else begin
      memChipSelN     <= ctl.chipSelN;
      memWriteStrobeN <= ctl.writeStrobeN;
      memOutStrobeN   <= ctl.outStrobeN;
      memAddr         <= ctl.addr;
      memDataOut      <= ctl.wdata;
      memDataOe       <= ctl.driveData;
    end
  end

endmodule

//--- bnr_mem_model.sv
// behavioural model of the byte-wide nonvolatile memory device
`timescale 1ns/1ns
module bnr_mem_model
  import bnr_pkg::*;
(
  input  wire logic      chipSelN,
  input  wire logic      writeStrobeN,
  input  wire logic      outStrobeN,
  input  wire bnr_addr_t addr,
  input  wire logic      hostOe,
  input  wire bnr_data_t hostData,
  output bnr_data_t      bus
);
  bnr_data_t mem [0:8191];
  bnr_addr_t latA;
  logic      arm   = 1'b0;
  logic      accOk = 1'b0;
  logic      oeOk  = 1'b0;
  logic      weOk  = 1'b1;
  bnr_data_t last  = 8'h00;
  wire logic drv   = !chipSelN && !outStrobeN && writeStrobeN
                     && accOk && oeOk && weOk;

  // an undriven bus shows the inverse of its last driven value
  assign bus = hostOe ? hostData : (drv ? mem[latA] : ~last);
  always @(bus) if (hostOe || drv) last = bus;

  always @(negedge chipSelN) begin
    latA = addr;
    arm = !writeStrobeN;
    accOk = 1'b0;
    #70 accOk = !chipSelN;
  end
  always @(negedge outStrobeN) begin
    oeOk = 1'b0;
    #12 oeOk = !outStrobeN;
  end
  always @(negedge writeStrobeN) begin
    weOk = 1'b0;
    arm = !chipSelN;
  end
  always @(posedge writeStrobeN) begin
    #10 weOk = 1'b1;
  end
  // whichever strobe rises first ends the write
  always @(posedge writeStrobeN or posedge chipSelN) begin
    if (arm) mem[latA] = hostData;
    arm = 1'b0;
  end
endmodule

//--- bnr_host_chk.sv
// timing checker on the host port pins
`timescale 1ns/1ns
module bnr_host_chk
  import bnr_pkg::*;
#(
  parameter int unsigned PWRUP_CYC = 20
)
(
  input wire logic      core_clk,
  input wire logic      rst_b,
  input wire logic      reqValid,
  input wire logic      reqReady,
  input wire logic      reqWrite,
  input wire bnr_addr_t reqAddr,
  input wire bnr_data_t reqWdata,
  input wire logic      rspValid,
  input wire bnr_data_t rspRdata,
  input wire logic      powerReady,
  input wire logic      memChipSelN,
  input wire logic      memWriteStrobeN,
  input wire logic      memOutStrobeN,
  input wire bnr_addr_t memAddr,
  input wire bnr_data_t memDataOut,
  input wire logic      memDataOe,
  input wire bnr_data_t memDataIn
);
  int unsigned upCnt;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      upCnt <= 0;
    end else if (upCnt < PWRUP_CYC) begin
      upCnt <= upCnt + 1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_pwrup_wait: assert property (
    !memChipSelN |-> upCnt >= PWRUP_CYC) else $error("early select");
  a_sel_hold: assert property (
    $fell(memChipSelN) |=> !memChipSelN) else $error("select too short");
  a_prechg_len: assert property (
    $rose(memChipSelN) |=> memChipSelN) else $error("precharge short");
  a_cycle_len: assert property (
    $fell(memChipSelN) |=> !$fell(memChipSelN) [*3])
    else $error("cycle too short");
  a_we_setup: assert property (
    $rose(memWriteStrobeN) |-> !$past(memChipSelN)
      && !$past(memChipSelN, 2)) else $error("strobe rose early");
  a_we_frame: assert property (
    $fell(memWriteStrobeN) |-> !memChipSelN && memOutStrobeN
      && memDataOe) else $error("strobe outside frame");
  a_no_fight: assert property (
    memDataOe |-> memOutStrobeN) else $error("bus contention");
  a_rd_answer: assert property (
    reqValid && reqReady && !reqWrite |-> ##7 rspValid ##1 !rspValid)
    else $error("read answer late");
endmodule

bind bnr_host bnr_host_chk #(.PWRUP_CYC(PWRUP_CYC)) i_chk (
  .core_clk(core_clk), .rst_b(rst_b), .reqValid(reqValid),
  .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr),
  .reqWdata(reqWdata), .rspValid(rspValid), .rspRdata(rspRdata),
  .powerReady(powerReady), .memChipSelN(memChipSelN),
  .memWriteStrobeN(memWriteStrobeN), .memOutStrobeN(memOutStrobeN),
  .memAddr(memAddr), .memDataOut(memDataOut), .memDataOe(memDataOe),
  .memDataIn(memDataIn));

//--- test_bnr_host.sv
// self-checking bench of the byte-wide memory host port
`timescale 1ns/1ns
module test_bnr_host
  import bnr_pkg::*;
;
  localparam int unsigned PU = 20;
  logic      core_clk, rst_b, reqValid, reqReady, reqWrite, rspValid;
  logic      powerReady, memChipSelN, memWriteStrobeN, memOutStrobeN;
  logic      memDataOe;
  bnr_addr_t reqAddr, memAddr;
  bnr_data_t reqWdata, rspRdata, memDataOut, memDataIn;
  int        n_errors = 0;
  int        check_count = 0;
  int        cyc = 0;

  bnr_host #(.PWRUP_CYC(PU)) i_dut (
    .core_clk(core_clk), .rst_b(rst_b), .reqValid(reqValid),
    .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqWdata(reqWdata), .rspValid(rspValid), .rspRdata(rspRdata),
    .powerReady(powerReady), .memChipSelN(memChipSelN),
    .memWriteStrobeN(memWriteStrobeN), .memOutStrobeN(memOutStrobeN),
    .memAddr(memAddr), .memDataOut(memDataOut), .memDataOe(memDataOe),
    .memDataIn(memDataIn));
  bnr_mem_model i_mem (
    .chipSelN(memChipSelN), .writeStrobeN(memWriteStrobeN),
    .outStrobeN(memOutStrobeN), .addr(memAddr), .hostOe(memDataOe),
    .hostData(memDataOut), .bus(memDataIn));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic idle;
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    // a port that never frees up counts as a mismatch
    if (n >= 50) chk(reqReady, 1'b1);
  endtask
  task automatic req(input logic w, input bnr_addr_t a, input bnr_data_t d);
    reqValid = 1'b1;
    reqWrite = w;
    reqAddr = a;
    reqWdata = d;
    idle();
    @(posedge core_clk);
    #1;
    reqValid = 1'b0;
  endtask
  task automatic wr(input bnr_addr_t a, input bnr_data_t d);
    req(1'b1, a, d);
    idle();
    chk(i_mem.mem[a], d);
  endtask
  task automatic rd(input bnr_addr_t a, input bnr_data_t d);
    int k;
    req(1'b0, a, 8'h00);
    k = 0;
    while (rspValid !== 1'b1 && k < 20) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk(k, 6);
    chk(rspRdata, d);
  endtask
  task automatic t_pwrup;
    int n;
    n = 0;
    while (powerReady !== 1'b1 && n < 200) begin
      chk(memChipSelN, 1'b1);
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(n >= PU, 1'b1);
    chk(powerReady, 1'b1);
  endtask
  task automatic t_wr_rd;
    bnr_addr_t a [4] = '{13'h0000, 13'h1fff, 13'h0aaa, 13'h1555};
    bnr_data_t d [4] = '{8'h5a, 8'ha5, 8'h00, 8'hff};
    for (int i = 0; i < 4; i++) wr(a[i], d[i]);
    for (int i = 0; i < 4; i++) rd(a[i], d[i]);
  endtask
  task automatic t_b2b;
    wr(13'h0123, 8'h11);
    wr(13'h0123, 8'h22);
    rd(13'h0123, 8'h22);
    rd(13'h0123, 8'h22);
    rd(13'h0aaa, 8'h00);
  endtask
  task automatic t_reset;
    req(1'b0, 13'h1fff, 8'h00);
    repeat (3) @(posedge core_clk);
    #1;
    rst_b = 1'b0;
    #1;
    chk({memChipSelN, memWriteStrobeN, memOutStrobeN, memDataOe, rspValid,
         rspRdata}, {5'b11100, 8'h00});
    repeat (3) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    t_pwrup();
    rd(13'h1fff, 8'ha5);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    rst_b = 1'b0;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = 13'h0000;
    reqWdata = 8'h00;
    repeat (3) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    t_pwrup();
    t_wr_rd();
    t_b2b();
    t_reset();
    stop_test();
  end
endmodule
